// ===== rtl/ldc_map.vh
`ifndef LDC_MAP_VH
`define LDC_MAP_VH

// Register offsets
`define LDC_ADDR_SHAPE_SRC 8'h15
`define LDC_ADDR_RAMP_DUR 8'h16
`define LDC_ADDR_TRIGGER 8'h17

// Field positions
`define LDC_SRC_BIT 0
`define LDC_SHAPE_BIT 1
`define LDC_UP_HI 7
`define LDC_UP_LO 4
`define LDC_DOWN_HI 3
`define LDC_DOWN_LO 0
`define LDC_START_DIM_BIT 4

// Reset values
`define LDC_RST_SHAPE_SRC 2'h0
`define LDC_RST_RAMP_DUR 8'h88
`define LDC_RST_START_DIM 1'b0
`define LDC_RST_TARGET 4'h0

// Timing: clock period, ramp tick, ramp durations
`define LDC_CLK_PERIOD_NS 40
`define LDC_TICK_US 100
`define LDC_TICK_CYC (`LDC_TICK_US * 1000 / `LDC_CLK_PERIOD_NS)
`define LDC_RAMP1_MS 120
`define LDC_RAMP2_MS 250
`define LDC_RAMP3_MS 380
`define LDC_RAMP4_MS 510
`define LDC_RAMP5_MS 770
`define LDC_RAMP6_MS 1000
`define LDC_RAMP7_MS 1600
`define LDC_RAMP8_MS 2100
`define LDC_RAMP9_MS 2600
`define LDC_RAMP10_MS 3100
`define LDC_RAMP11_MS 4200
`define LDC_RAMP12_MS 5200
`define LDC_RAMP13_MS 6200
`define LDC_RAMP14_MS 7300
`define LDC_RAMP15_MS 8300

// Ramp resolution
`define LDC_LEVEL_MAX 8'hFF
`define LDC_ACC_STEP 17'h000FF

`endif

// ===== rtl/ldc_ramp.v
`timescale 1ns/10ps
`default_nettype none
`include "ldc_map.vh"

module ldc_ramp (
  input wire clock_i,
  input wire rst_i,
  input wire tick_i,
  input wire target_i,
  input wire ramp_en_i,
  input wire [16:0] up_ticks_i,
  input wire [16:0] down_ticks_i,
  output wire [7:0] pos_o
);
  localparam [2:0] ST_HOLD = 3'b001;
  localparam [2:0] ST_UP = 3'b010;
  localparam [2:0] ST_DOWN = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [7:0] pos_reg;
  reg [7:0] pos_next;
  reg [16:0] acc_reg;
  reg [16:0] acc_next;
  reg [16:0] sum;

  assign pos_o = pos_reg;

  always @* begin
    state_next = state_reg;
    pos_next = pos_reg;
    acc_next = acc_reg;
    sum = acc_reg + `LDC_ACC_STEP;
    case (state_reg)
      ST_HOLD: begin
        if (target_i && pos_reg != `LDC_LEVEL_MAX) begin
          if (!ramp_en_i || up_ticks_i == 17'h00000) begin
            pos_next = `LDC_LEVEL_MAX;
          end else begin
            state_next = ST_UP;
            acc_next = 17'h00000;
          end
        end else if (!target_i && pos_reg != 8'h00) begin
          if (!ramp_en_i || down_ticks_i == 17'h00000) begin
            pos_next = 8'h00;
          end else begin
            state_next = ST_DOWN;
            acc_next = 17'h00000;
          end
        end
      end
      ST_UP: begin
        if (!target_i) begin
          state_next = ST_HOLD;
        end else if (!ramp_en_i || up_ticks_i == 17'h00000) begin
          pos_next = `LDC_LEVEL_MAX;
          state_next = ST_HOLD;
        end else if (tick_i) begin
          if (sum >= up_ticks_i) begin
            pos_next = pos_reg + 8'h01;
            acc_next = sum - up_ticks_i;
            if (pos_reg == 8'hFE) begin
              state_next = ST_HOLD;
            end
          end else begin
            acc_next = sum;
          end
        end
      end
      ST_DOWN: begin
        if (target_i) begin
          state_next = ST_HOLD;
        end else if (!ramp_en_i || down_ticks_i == 17'h00000) begin
          pos_next = 8'h00;
          state_next = ST_HOLD;
        end else if (tick_i) begin
          if (sum >= down_ticks_i) begin
            pos_next = pos_reg - 8'h01;
            acc_next = sum - down_ticks_i;
            if (pos_reg == 8'h01) begin
              state_next = ST_HOLD;
            end
          end else begin
            acc_next = sum;
          end
        end
      end
      default: begin
        state_next = ST_HOLD;
      end
    endcase
  end

  always @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= ST_HOLD;
      pos_reg <= 8'h00;
      acc_reg <= 17'h00000;
    end else begin
      state_reg <= state_next;
      pos_reg <= pos_next;
      acc_reg <= acc_next;
    end
  end
endmodule // ldc_ramp

`default_nettype wire

// ===== rtl/ldc_top.v
// Operation
// - Ramp curve is logarithmic when shape bit is 0, linear when 1.
// - Source bit 0 uses internal PWM generator, 1 uses external PWM pin.
// - Rising ramp time from code in bits 7:4; 0000 immediate, default 0x08.
// - Falling ramp time from code in bits 3:0, same table, default 0x08.
// - One ramp time setting shared by all four channels.
// - Ramp-select bit 4: 0 switches directly, 1 ramps with programmed times.
// - Reading target bits returns live channel on/off status.
// - Writing 1 turns channel on or ramps up; 0 turns off or down.
// - Target write acts only on channels whose mode selects PWM.
`timescale 1ns/10ps
`default_nettype none
`include "ldc_map.vh"

module ldc_top #(
  parameter integer TICK_CYC = `LDC_TICK_CYC
) (
  input wire clock_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  output wire [7:0] reg_rdata_o,
  input wire [3:0] chan_pwm_mode_i,
  input wire ext_pwm_i,
  output wire led_sink_one_o,
  output wire led_sink_two_o,
  output wire led_sink_three_o,
  output wire led_sink_four_o
);
  // Last count of the ramp tick divider: period in clock cycles minus one
  localparam integer TICK_LAST_INT = TICK_CYC - 1;
  localparam [11:0] TICK_LAST = TICK_LAST_INT[11:0];

  reg [1:0] shape_src_reg;
  reg [7:0] ramp_dur_reg;
  reg start_dim_reg;
  reg [3:0] target_reg;
  reg [3:0] target_next;
  reg [7:0] rdata_reg;
  reg [7:0] rdata_next;
  reg [11:0] tick_cnt_reg;
  reg tick_reg;
  reg [7:0] pwm_cnt_reg;
  reg [3:0] sink_reg;
  reg [3:0] sink_next;
  wire [16:0] up_ticks;
  wire [16:0] down_ticks;
  wire [31:0] pos_all;
  wire [3:0] status;
  integer i;

  // Ramp code to tick count of a full sweep, zero for immediate
  function [16:0] ramp_ticks;
    input [3:0] code;
    reg [31:0] ms;
    reg [31:0] t;
    begin
      case (code)
        4'h1: ms = `LDC_RAMP1_MS;
        4'h2: ms = `LDC_RAMP2_MS;
        4'h3: ms = `LDC_RAMP3_MS;
        4'h4: ms = `LDC_RAMP4_MS;
        4'h5: ms = `LDC_RAMP5_MS;
        4'h6: ms = `LDC_RAMP6_MS;
        4'h7: ms = `LDC_RAMP7_MS;
        4'h8: ms = `LDC_RAMP8_MS;
        4'h9: ms = `LDC_RAMP9_MS;
        4'hA: ms = `LDC_RAMP10_MS;
        4'hB: ms = `LDC_RAMP11_MS;
        4'hC: ms = `LDC_RAMP12_MS;
        4'hD: ms = `LDC_RAMP13_MS;
        4'hE: ms = `LDC_RAMP14_MS;
        4'hF: ms = `LDC_RAMP15_MS;
        default: ms = 32'h00000000;
      endcase
      t = ms * 1000 / `LDC_TICK_US;
      ramp_ticks = t[16:0];
    end
  endfunction

  // Exponential mapping of ramp position, gives a log-looking brightness
  function [7:0] shape_level;
    input [7:0] pos;
    input linear;
    reg [12:0] v;
    begin
      v = {7'h00, 1'b1, pos[4:0]} << pos[7:5];
      if (linear) begin
        shape_level = pos;
      end else if (pos == `LDC_LEVEL_MAX) begin
        // Top of the log curve must reach full on
        shape_level = `LDC_LEVEL_MAX;
      end else begin
        shape_level = v[12:5] - 8'h01;
      end
    end
  endfunction

  // Gate of one sink: counter compare or external pin
  function sink_on;
    input [7:0] level;
    input [7:0] cnt;
    input ext;
    input src_ext;
    begin
      if (src_ext) begin
        sink_on = ext & (level != 8'h00);
      end else begin
        sink_on = (level == `LDC_LEVEL_MAX) | (cnt < level);
      end
    end
  endfunction

  // Shared ramp times for every channel
  assign up_ticks = ramp_ticks(ramp_dur_reg[`LDC_UP_HI:`LDC_UP_LO]);
  assign down_ticks = ramp_ticks(ramp_dur_reg[`LDC_DOWN_HI:`LDC_DOWN_LO]);

  // One ramp engine per channel
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_chan
      ldc_ramp u_ramp (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .tick_i(tick_reg),
        .target_i(target_reg[g]),
        .ramp_en_i(start_dim_reg),
        .up_ticks_i(up_ticks),
        .down_ticks_i(down_ticks),
        .pos_o(pos_all[8*g+7:8*g])
      );
      assign status[g] = pos_all[8*g+7:8*g] != 8'h00;
    end
  endgenerate

  // Writes reach only channels in PWM mode
  always @* begin
    target_next = target_reg;
    if (reg_wr_i && reg_addr_i == `LDC_ADDR_TRIGGER) begin
      target_next = (reg_wdata_i[3:0] & chan_pwm_mode_i) |
                    (target_reg & ~chan_pwm_mode_i);
    end
  end

  // Read mux, status bits show live channel state
  always @* begin
    case (reg_addr_i)
      `LDC_ADDR_SHAPE_SRC: rdata_next = {6'h00, shape_src_reg};
      `LDC_ADDR_RAMP_DUR: rdata_next = ramp_dur_reg;
      `LDC_ADDR_TRIGGER: rdata_next = {3'h0, start_dim_reg, status};
      default: rdata_next = 8'h00;
    endcase
  end

  // Sink gates, registered below
  always @* begin
    sink_next = 4'h0;
    for (i = 0; i < 4; i = i + 1) begin
      sink_next[i] = sink_on(shape_level(pos_all[8*i+:8], shape_src_reg[`LDC_SHAPE_BIT]),
                             pwm_cnt_reg, ext_pwm_i,
                             shape_src_reg[`LDC_SRC_BIT]);
    end
  end

  // Register file writes and read capture
  always @(posedge clock_i) begin
    if (rst_i) begin
      shape_src_reg <= `LDC_RST_SHAPE_SRC;
      ramp_dur_reg <= `LDC_RST_RAMP_DUR;
      start_dim_reg <= `LDC_RST_START_DIM;
      target_reg <= `LDC_RST_TARGET;
      rdata_reg <= 8'h00;
    end else begin
      target_reg <= target_next;
      if (reg_wr_i && reg_addr_i == `LDC_ADDR_SHAPE_SRC) begin
        shape_src_reg <= reg_wdata_i[1:0];
      end
      if (reg_wr_i && reg_addr_i == `LDC_ADDR_RAMP_DUR) begin
        ramp_dur_reg <= reg_wdata_i;
      end
      if (reg_wr_i && reg_addr_i == `LDC_ADDR_TRIGGER) begin
        start_dim_reg <= reg_wdata_i[`LDC_START_DIM_BIT];
      end
      if (reg_rd_i) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // Ramp tick divider and internal PWM counter
  always @(posedge clock_i) begin
    if (rst_i) begin
      tick_cnt_reg <= 12'h000;
      tick_reg <= 1'b0;
      pwm_cnt_reg <= 8'h00;
      sink_reg <= 4'h0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      sink_reg <= sink_next;
      if (tick_cnt_reg == TICK_LAST) begin
        tick_cnt_reg <= 12'h000;
        tick_reg <= 1'b1;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 12'h001;
        tick_reg <= 1'b0;
      end
    end
  end

  // Port drive
  assign reg_rdata_o = rdata_reg;
  assign led_sink_one_o = sink_reg[0];
  assign led_sink_two_o = sink_reg[1];
  assign led_sink_three_o = sink_reg[2];
  assign led_sink_four_o = sink_reg[3];
endmodule // ldc_top

`default_nettype wire

// ===== verification/ldc_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ldc_checker (
  input wire clock_i,
  input wire rst_i,
  input wire [7:0] reg_addr_i,
  input wire reg_wr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire [3:0] chan_pwm_mode_i,
  input wire led_sink_one_o
);
  reg src_reg;
  wire w17 = reg_wr_i && reg_addr_i == 8'h17 && chan_pwm_mode_i[0] && !reg_wdata_i[4];
  // Tracks source select so the full-on check skips external mode
  always @(posedge clock_i) begin
    if (rst_i)
      src_reg <= 1'b0;
    else if (reg_wr_i && reg_addr_i == 8'h15)
      src_reg <= reg_wdata_i[0];
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  property p_unmap;
    reg_rd_i && (reg_addr_i < 8'h15 || reg_addr_i > 8'h17) |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hi15;
    reg_rd_i && reg_addr_i == 8'h15 |=> reg_rdata_o[7:2] == 6'h00;
  endproperty
  a_hi15: assert property (p_hi15) else $error("control upper bits set");
  property p_hi17;
    reg_rd_i && reg_addr_i == 8'h17 |=> reg_rdata_o[7:5] == 3'h0;
  endproperty
  a_hi17: assert property (p_hi17) else $error("trigger upper bits set");
  property p_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_wr15;
    reg_wr_i && reg_addr_i == 8'h15 ##1 !reg_wr_i
      ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h15
      |=> reg_rdata_o[1:0] == $past(reg_wdata_i[1:0], 3);
  endproperty
  a_wr15: assert property (p_wr15) else $error("control readback wrong");
  property p_wr16;
    reg_wr_i && reg_addr_i == 8'h16 ##1 !reg_wr_i
      ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 8'h16
      |=> reg_rdata_o == $past(reg_wdata_i, 3);
  endproperty
  a_wr16: assert property (p_wr16) else $error("ramp code readback wrong");
  property p_on;
    w17 && reg_wdata_i[0] && !src_reg ##1 (!reg_wr_i)[*3] |=> led_sink_one_o;
  endproperty
  a_on: assert property (p_on) else $error("direct on failed");
  property p_off;
    w17 && !reg_wdata_i[0] ##1 (!reg_wr_i)[*3] |=> !led_sink_one_o;
  endproperty
  a_off: assert property (p_off) else $error("direct off failed");
  c_ramp: cover property (reg_wr_i && reg_addr_i == 8'h17 && reg_wdata_i[4]);
  c_ext: cover property (reg_wr_i && reg_addr_i == 8'h15 && reg_wdata_i[0]);
  c_on: cover property ($rose(led_sink_one_o));
endmodule // ldc_checker
bind ldc_top ldc_checker u_chk (.clock_i, .rst_i, .reg_addr_i, .reg_wr_i, .reg_wdata_i,
  .reg_rd_i, .reg_rdata_o, .chan_pwm_mode_i, .led_sink_one_o);
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  reg clock_i = 1'b0;
  reg rst_i = 1'b1;
  reg [7:0] addr = 8'h00;
  reg [7:0] wdata = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [3:0] mode = 4'h0;
  reg ext = 1'b0;
  wire [7:0] rdata;
  wire [3:0] sink;
  integer err_total = 0;
  integer check_count = 0;
  always #20 clock_i = ~clock_i;
  // One ramp tick per clock keeps ramp checks short
  ldc_top #(.TICK_CYC(1)) u_dut (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wr_i(wr),
    .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .chan_pwm_mode_i(mode),
    .ext_pwm_i(ext), .led_sink_one_o(sink[0]), .led_sink_two_o(sink[1]),
    .led_sink_three_o(sink[2]), .led_sink_four_o(sink[3]));
  task chk(input string name, input [7:0] exp, input [7:0] got);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
    end
  endtask
  task chk_duty(input [8:0] exp, input string name);
    reg [8:0] cnt;
    begin
      cnt = 9'h000;
      repeat (256) begin
        @(negedge clock_i);
        if (sink === 4'hF)
          cnt = cnt + 9'h001;
      end
      check_count = check_count + 1;
      if (cnt !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, cnt);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [7:0] d);
    begin
      @(negedge clock_i);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clock_i);
      wr = 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a, input [7:0] exp, input string name);
    begin
      @(negedge clock_i);
      addr = a;
      rd = 1'b1;
      @(negedge clock_i);
      rd = 1'b0;
      @(negedge clock_i);
      chk(name, exp, rdata);
    end
  endtask
  task sinks(input [3:0] exp);
    begin
      repeat (4) @(negedge clock_i);
      chk("sinks", {4'h0, exp}, {4'h0, sink});
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(negedge clock_i);
    rst_i = 1'b0;
    rd_reg(8'h15, 8'h00, "ctrl rst");
    rd_reg(8'h16, 8'h88, "ramp rst");
    rd_reg(8'h17, 8'h00, "trig rst");
    rd_reg(8'h30, 8'h00, "unmapped");
    wr_reg(8'h15, 8'hFF);
    rd_reg(8'h15, 8'h03, "ctrl rw");
    wr_reg(8'h16, 8'h5A);
    rd_reg(8'h16, 8'h5A, "ramp rw");
    wr_reg(8'h15, 8'h00);
    mode = 4'h5;
    wr_reg(8'h17, 8'h0F);
    sinks(4'h5);
    rd_reg(8'h17, 8'h05, "status part");
    mode = 4'hF;
    wr_reg(8'h17, 8'h0F);
    sinks(4'hF);
    wr_reg(8'h15, 8'h01);
    sinks(4'h0);
    ext = 1'b1;
    sinks(4'hF);
    wr_reg(8'h17, 8'h00);
    sinks(4'h0);
    wr_reg(8'h16, 8'h00);
    wr_reg(8'h17, 8'h1F);
    sinks(4'hF);
    rd_reg(8'h17, 8'h1F, "no ramp");
    wr_reg(8'h16, 8'h11);
    wr_reg(8'h17, 8'h10);
    sinks(4'hF);
    rd_reg(8'h17, 8'h1F, "ramping");
    wr_reg(8'h16, 8'h00);
    wr_reg(8'h17, 8'h10);
    sinks(4'h0);
    wr_reg(8'h16, 8'h11);
    wr_reg(8'h17, 8'h1F);
    sinks(4'h0);
    wr_reg(8'h15, 8'h00);
    repeat (1250) @(negedge clock_i);
    chk_duty(9'h100, "log full");
    wr_reg(8'h17, 8'h10);
    repeat (1140) @(negedge clock_i);
    rd_reg(8'h17, 8'h1F, "fall mid");
    repeat (100) @(negedge clock_i);
    rd_reg(8'h17, 8'h10, "fall end");
    wr_reg(8'h16, 8'hF1);
    wr_reg(8'h15, 8'h02);
    wr_reg(8'h17, 8'h1F);
    repeat (360) @(negedge clock_i);
    chk_duty(9'h001, "lin step");
    wr_reg(8'h15, 8'h00);
    chk_duty(9'h000, "log step");
    test_done;
  end
  initial begin
    #400000;
    err_total = err_total + 1;
    test_done;
  end
endmodule // tb_top
`default_nettype wire
